// ### core/emrid_pkg.sv
package emrid_pkg;
   // serial command codes, four bits, sent lsb first
   localparam logic [3:0] CMD_EXECUTE = 4'h0;
   localparam logic [3:0] CMD_REG_OUT = 4'h1;
   localparam logic [3:0] CMD_CFG_READ = 4'h2;
   localparam int CMD_BITS = 4;
   localparam int OPERAND_BITS = 24;
   localparam int OUT_BITS = 16;
   localparam int GAP_CLOCKS = 8;

   // table page that maps table reads onto executive memory
   localparam logic [7:0] EXEC_PAGE = 8'h80;

   // identification region
   localparam logic [23:0] IDENTITY_ADDR = 24'hff0000;
   localparam logic [23:0] REVISION_ADDR = 24'hff0002;
   localparam int FAMILY_LSB = 6;
   localparam int PART_LSB = 0;
   localparam int MAJOR_LSB = 6;
   localparam int MINOR_LSB = 0;

   // instruction words understood by the executor
   localparam logic [23:0] OP_MOV_W0_PAGE = 24'h880190;
   localparam logic [23:0] OP_CLR_RDPTR = 24'heb0300;
   localparam logic [23:0] OP_MOV_VIS_WRPTR = 24'h207847;
   localparam logic [23:0] OP_RDL = 24'hba0b96;
   localparam logic [23:0] OP_RDL_POSTINC = 24'hba0bb6;
   localparam logic [23:0] OP_RDHB_POSTINC = 24'hbadbb6;
   localparam logic [23:0] OP_RDHB_PREINC = 24'hbad3d6;
   localparam logic [3:0] OP_MOVLIT_HI = 4'h2;
   localparam logic [3:0] OP_MOVLIT_W0 = 4'h0;
   localparam logic [15:0] PTR_BYTE_STEP = 16'h0001;
   localparam logic [15:0] PTR_WORD_STEP = 16'h0002;

   typedef enum logic [1:0] {
      ST_CMD,
      ST_OPER,
      ST_GAP,
      ST_OUT
   } emrid_state_t;
endpackage : emrid_pkg

// ### core/emrid_pin_if.sv
`timescale 1ns/1ps
interface emrid_pin_if;
   logic rise;
   logic data;
   modport sync (output rise, output data);
   modport core (input rise, input data);
endinterface : emrid_pin_if

// ### core/emrid_pin_sync.sv
`timescale 1ns/1ps
module emrid_pin_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic prog_clk_in,
   input wire logic prog_data_in,
   emrid_pin_if.sync pin
);
   logic [1:0] clk_meta_q;
   logic [1:0] dat_meta_q;
   logic clk_last_q;

   // two stages on both pins; only stage two feeds the edge finder
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         clk_meta_q <= 2'h0;
         dat_meta_q <= 2'h0;
         clk_last_q <= 1'b0;
      end
      else
      begin
         clk_meta_q <= {clk_meta_q[0], prog_clk_in};
         dat_meta_q <= {dat_meta_q[0], prog_data_in};
         clk_last_q <= clk_meta_q[1];
      end
   end

   // data passes the same depth as the clock, so setup is kept
   assign pin.rise = clk_meta_q[1] & ~clk_last_q;
   assign pin.data = dat_meta_q[1];
endmodule : emrid_pin_sync

// ### core/emrid_core.sv
`timescale 1ns/1ps
// Summary of operation
// - register-out command shifts the visible register out on the data line
// - two 16-bit identification words readable by the config read command
// - identification words are read-only and readable under code protection
// - first identification word holds family code and part code
// - second identification word holds major and minor revision
module emrid_core
   import emrid_pkg::*;
#(
   parameter int EXEC_WORDS = 1024,
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
   parameter logic [5:0] PART_CODE = 6'h15, // arbitrary value
   parameter logic [2:0] MAJOR_REV = 3'h1, // arbitrary value
   parameter logic [2:0] MINOR_REV = 3'h2 // arbitrary value
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic prog_clk_in,
   input wire logic prog_data_in,
   output logic prog_data_out,
   output logic prog_data_oe_out,
   input wire logic code_protect_in,
   input wire logic mem_wr_in,
   input wire logic [$clog2(EXEC_WORDS)-1:0] mem_addr_in,
   input wire logic [23:0] mem_data_in,
   output logic [7:0] table_page_out
);
   localparam int AW = $clog2(EXEC_WORDS);

   generate
      if (EXEC_WORDS < 2 || (1 << AW) != EXEC_WORDS || AW > 15)
      begin : g_bad_size
         $error("EXEC_WORDS must be a power of two between 2 and 32768");
      end
   endgenerate

   localparam logic [15:0] ID_WORD =
      16'((16'(FAMILY_CODE) << FAMILY_LSB) | (16'(PART_CODE) << PART_LSB));
   localparam logic [15:0] REV_WORD =
      16'((16'(MAJOR_REV) << MAJOR_LSB) | (16'(MINOR_REV) << MINOR_LSB));

   emrid_pin_if pin ();

   emrid_pin_sync u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .prog_clk_in(prog_clk_in),
      .prog_data_in(prog_data_in),
      .pin(pin)
   );

   logic [23:0] exec_mem [EXEC_WORDS];
   emrid_state_t st_q;
   logic [4:0] cnt_q;
   logic [23:0] sh_q;
   logic [23:0] sh_d;
   logic cfg_q;
   logic [15:0] out_q;
   logic [15:0] visi_q;
   logic [15:0] w0_q;
   logic [15:0] rdptr_q;
   logic wrhi_q;
   logic [7:0] page_q;
   logic cmd_done;
   logic oper_done;
   logic gap_done;
   logic out_done;

   // table read: executive memory only when the page selects it and code protection is off
   function automatic logic [15:0] fetch(input logic [15:0] ptr, input logic hi);
      logic [23:0] w;
      w = 24'h0;
      if (page_q == EXEC_PAGE && !code_protect_in)
         w = exec_mem[ptr[AW:1]];
      return hi ? 16'(w[23:16]) : w[15:0];
   endfunction : fetch

   function automatic logic [15:0] id_lookup(input logic [23:0] addr);
      logic [15:0] v;
      v = 16'h0;
      if (addr == IDENTITY_ADDR)
         v = ID_WORD;
      else if (addr == REVISION_ADDR)
         v = REV_WORD;
      return v;
   endfunction : id_lookup

   always_ff @(posedge clk_in)
   begin
      if (mem_wr_in)
         exec_mem[mem_addr_in] <= mem_data_in;
   end

   assign sh_d = {pin.data, sh_q[23:1]};
   assign cmd_done = st_q == ST_CMD && pin.rise && cnt_q == 5'(CMD_BITS - 1);
   assign oper_done = st_q == ST_OPER && pin.rise && cnt_q == 5'(OPERAND_BITS - 1);
   assign gap_done = st_q == ST_GAP && pin.rise && cnt_q == 5'(GAP_CLOCKS - 1);
   assign out_done = st_q == ST_OUT && pin.rise && cnt_q == 5'(OUT_BITS - 1);

   // link sequencer; unknown commands take no operand
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_q <= ST_CMD;
         cnt_q <= 5'h0;
         sh_q <= 24'h0;
         cfg_q <= 1'b0;
      end
      else if (pin.rise)
      begin
         sh_q <= sh_d;
         cnt_q <= cnt_q + 5'h1;
         case (st_q)
            ST_CMD:
               if (cmd_done)
               begin
                  cnt_q <= 5'h0;
                  cfg_q <= sh_d[23:20] == CMD_CFG_READ;
                  if (sh_d[23:20] == CMD_EXECUTE || sh_d[23:20] == CMD_CFG_READ)
                     st_q <= ST_OPER;
                  else if (sh_d[23:20] == CMD_REG_OUT)
                     st_q <= ST_GAP;
               end
            ST_OPER:
               if (oper_done)
               begin
                  cnt_q <= 5'h0;
                  st_q <= cfg_q ? ST_GAP : ST_CMD;
               end
            ST_GAP:
               if (gap_done)
               begin
                  cnt_q <= 5'h0;
                  st_q <= ST_OUT;
               end
            ST_OUT:
               if (out_done)
               begin
                  cnt_q <= 5'h0;
                  st_q <= ST_CMD;
               end
            default:
            begin
               st_q <= ST_CMD;
               cnt_q <= 5'h0;
            end
         endcase
      end
   end

   // word to send, captured when the request is complete
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         out_q <= 16'h0;
      else if (cmd_done && sh_d[23:20] == CMD_REG_OUT)
         out_q <= visi_q;
      else if (oper_done && cfg_q)
         out_q <= id_lookup(sh_d);
      else if (st_q == ST_OUT && pin.rise)
         out_q <= {1'b0, out_q[15:1]};
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         prog_data_out <= 1'b0;
         prog_data_oe_out <= 1'b0;
      end
      else if (gap_done)
      begin
         prog_data_out <= out_q[0];
         prog_data_oe_out <= 1'b1;
      end
      else if (out_done)
      begin
         prog_data_out <= 1'b0;
         prog_data_oe_out <= 1'b0;
      end
      else if (st_q == ST_OUT && pin.rise)
         prog_data_out <= out_q[1];
   end

   // executor for the small instruction subset of the read-back flow
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         visi_q <= 16'h0;
         w0_q <= 16'h0;
         rdptr_q <= 16'h0;
         wrhi_q <= 1'b0;
         page_q <= 8'h0;
      end
      else if (oper_done && !cfg_q)
      begin
         case (sh_d)
            OP_MOV_W0_PAGE:
               page_q <= w0_q[7:0];
            OP_CLR_RDPTR:
               rdptr_q <= 16'h0;
            OP_MOV_VIS_WRPTR:
               wrhi_q <= 1'b0;
            OP_RDL:
               visi_q <= fetch(rdptr_q, 1'b0);
            OP_RDL_POSTINC:
            begin
               visi_q <= fetch(rdptr_q, 1'b0);
               rdptr_q <= rdptr_q + PTR_WORD_STEP;
            end
            OP_RDHB_POSTINC:
            begin
               if (wrhi_q)
                  visi_q[15:8] <= 8'(fetch(rdptr_q, 1'b1));
               else
                  visi_q[7:0] <= 8'(fetch(rdptr_q, 1'b1));
               rdptr_q <= rdptr_q + PTR_BYTE_STEP;
               wrhi_q <= 1'b1;
            end
            OP_RDHB_PREINC:
            begin
               if (wrhi_q)
                  visi_q[15:8] <= 8'(fetch(rdptr_q + PTR_BYTE_STEP, 1'b1));
               else
                  visi_q[7:0] <= 8'(fetch(rdptr_q + PTR_BYTE_STEP, 1'b1));
               rdptr_q <= rdptr_q + PTR_BYTE_STEP;
            end
            default:
               if (sh_d[23:20] == OP_MOVLIT_HI && sh_d[3:0] == OP_MOVLIT_W0)
                  w0_q <= sh_d[19:4];
         endcase
      end
   end

   assign table_page_out = page_q;

   property p_regout_word;
      @(posedge clk_in) disable iff (rst_in)
      cmd_done && sh_d[23:20] == CMD_REG_OUT |=> out_q == $past(visi_q);
   endproperty
   a_regout_word: assert property (p_regout_word)
      else $error("register-out did not capture visible register");
   sequence s_send_start;
      gap_done ##1 prog_data_oe_out;
   endsequence
   property p_drive_window;
      @(posedge clk_in) disable iff (rst_in)
      gap_done |=> prog_data_oe_out && st_q == ST_OUT && prog_data_out == $past(out_q[0]);
   endproperty
   a_drive_window: assert property (p_drive_window)
      else $error("data not driven at start of shift-out");
   property p_oe_in_out;
      @(posedge clk_in) disable iff (rst_in)
      s_send_start |-> prog_data_oe_out throughout (st_q == ST_OUT) [*2];
   endproperty
   a_oe_in_out: assert property (p_oe_in_out)
      else $error("data enable dropped during shift-out");
   property p_id_read;
      @(posedge clk_in) disable iff (rst_in)
      oper_done && cfg_q && sh_d == IDENTITY_ADDR |=> out_q == ID_WORD;
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("identity word not returned by config read");
   property p_id_protected;
      @(posedge clk_in) disable iff (rst_in)
      oper_done && cfg_q && code_protect_in && sh_d == REVISION_ADDR
         |=> out_q == REV_WORD;
   endproperty
   a_id_protected: assert property (p_id_protected)
      else $error("revision word hidden under code protection");
   property p_family_field;
      @(posedge clk_in) disable iff (rst_in)
      oper_done && cfg_q && sh_d == IDENTITY_ADDR
         |=> out_q[13:6] == FAMILY_CODE && out_q[5:0] == PART_CODE;
   endproperty
   a_family_field: assert property (p_family_field)
      else $error("identity fields misplaced");
   property p_rev_field;
      @(posedge clk_in) disable iff (rst_in)
      oper_done && cfg_q && sh_d == REVISION_ADDR
         |=> out_q[8:6] == MAJOR_REV && out_q[2:0] == MINOR_REV;
   endproperty
   a_rev_field: assert property (p_rev_field)
      else $error("revision fields misplaced");
endmodule : emrid_core

// ### testbench/emrid_prog_model.sv
`timescale 1ns/1ps
module emrid_prog_model
   import emrid_pkg::*;
(
   input wire logic clk_in,
   input wire logic pin_in,
   input wire logic oe_in,
   output logic link_clk_out,
   output logic host_d_out
);
   // link clock stands low between frames
   initial
   begin
      link_clk_out = 1'b0;
      host_d_out = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk_in);
      #2;
   endtask : half
   // released line toggles so stale data never reads back
   task automatic cyc(input logic drv, input logic d, output logic s, output logic oe);
      host_d_out = drv ? d : ~host_d_out;
      half();
      s = pin_in;
      oe = oe_in;
      link_clk_out = 1'b1;
      half();
      link_clk_out = 1'b0;
   endtask : cyc
   task automatic send(input logic [3:0] cmd, input logic [23:0] op, input int n);
      logic s, oe;
      logic [27:0] w = {op, cmd};
      for (int i = 0; i < CMD_BITS + n; i++)
         cyc(1'b1, w[i], s, oe);
   endtask : send
   // gap with line released, then sixteen bits lsb first
   task automatic shift_in(output logic [15:0] v, output logic ok);
      logic s, oe;
      ok = 1'b1;
      for (int i = 0; i < GAP_CLOCKS + OUT_BITS; i++)
      begin
         cyc(1'b0, 1'b0, s, oe);
         if (i >= GAP_CLOCKS)
            v[i - GAP_CLOCKS] = s;
         if (oe !== (i >= GAP_CLOCKS))
            ok = 1'b0;
      end
   endtask : shift_in
   task automatic reg_out(output logic [15:0] v, output logic ok);
      send(CMD_REG_OUT, 24'h000000, 0);
      shift_in(v, ok);
      send(CMD_EXECUTE, 24'h000000, OPERAND_BITS);
   endtask : reg_out
   task automatic cfg_read(input logic [23:0] a, output logic [15:0] v, output logic ok);
      send(CMD_CFG_READ, a, OPERAND_BITS);
      shift_in(v, ok);
   endtask : cfg_read
endmodule : emrid_prog_model

// ### testbench/tb_exec_memory_readback_and_id.sv
`timescale 1ns/1ps
module tb_exec_memory_readback_and_id;
   import emrid_pkg::*;
   localparam int WORDS = 16;
   localparam logic [7:0] FAM = 8'ha3; // arbitrary value
   localparam logic [5:0] PART = 6'h2c; // arbitrary value
   localparam logic [2:0] MAJ = 3'h5; // arbitrary value
   localparam logic [2:0] MIN = 3'h6; // arbitrary value
   logic clk_in, rst_in, link_clk, host_d, pin, dout, oe, protect, mem_wr, ok;
   logic [3:0] mem_addr;
   logic [23:0] mem_data;
   logic [7:0] page;
   logic [15:0] v;
   logic [23:0] image [WORDS];
   int error_cnt = 0;
   int n_tests = 0;
   int cycles = 0;
   // device owns the pin only while its enable is high
   assign pin = oe ? dout : host_d;
   emrid_core #(.EXEC_WORDS(WORDS), .FAMILY_CODE(FAM), .PART_CODE(PART), .MAJOR_REV(MAJ),
      .MINOR_REV(MIN)) dut (.clk_in(clk_in), .rst_in(rst_in), .prog_clk_in(link_clk),
      .prog_data_in(pin), .prog_data_out(dout), .prog_data_oe_out(oe),
      .code_protect_in(protect), .mem_wr_in(mem_wr), .mem_addr_in(mem_addr),
      .mem_data_in(mem_data), .table_page_out(page));
   emrid_prog_model prog (.clk_in(clk_in), .pin_in(pin), .oe_in(oe),
      .link_clk_out(link_clk), .host_d_out(host_d));
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // readback pass is about 22k cycles
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 50000)
      begin
         error_cnt++;
         $display("MISMATCH %0t timeout", $time);
         final_report();
      end
   end
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task automatic check_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask : check_flag
   task automatic read_check(input logic [15:0] exp);
      prog.reg_out(v, ok);
      check_word(v, exp);
      check_flag(ok, 1'b1);
   endtask : read_check
   task automatic t_ident();
      prog.cfg_read(IDENTITY_ADDR, v, ok);
      check_word(v, {2'b00, FAM, PART});
      prog.cfg_read(REVISION_ADDR, v, ok);
      check_word(v, {7'h00, MAJ, 3'h0, MIN});
      check_flag(ok, 1'b1);
      prog.cfg_read(24'hff0004, v, ok);
      check_word(v, 16'h0000);
      protect = 1'b1;
      prog.cfg_read(IDENTITY_ADDR, v, ok);
      check_word(v, {2'b00, FAM, PART});
      prog.cfg_read(REVISION_ADDR, v, ok);
      check_word(v, {7'h00, MAJ, 3'h0, MIN});
      check_flag(ok, 1'b1);
      protect = 1'b0;
   endtask : t_ident
   task automatic t_readback();
      for (int i = 0; i < WORDS; i++)
      begin
         image[i] = 24'h3c5a96 ^ (24'(i) * 24'h0b0d07);
         mem_wr = 1'b1;
         mem_addr = 4'(i);
         mem_data = image[i];
         @(posedge clk_in);
         #2;
      end
      mem_wr = 1'b0;
      prog.send(CMD_EXECUTE, {OP_MOVLIT_HI, 8'h00, EXEC_PAGE, OP_MOVLIT_W0}, OPERAND_BITS);
      prog.send(CMD_EXECUTE, OP_MOV_W0_PAGE, OPERAND_BITS);
      check_word({8'h00, page}, {8'h00, EXEC_PAGE});
      prog.send(CMD_EXECUTE, OP_CLR_RDPTR, OPERAND_BITS);
      for (int p = 0; p < WORDS; p += 2)
      begin
         prog.send(CMD_EXECUTE, OP_MOV_VIS_WRPTR, OPERAND_BITS);
         prog.send(CMD_EXECUTE, OP_RDL, OPERAND_BITS);
         read_check(image[p][15:0]);
         prog.send(CMD_EXECUTE, OP_RDHB_POSTINC, OPERAND_BITS);
         prog.send(CMD_EXECUTE, OP_RDHB_PREINC, OPERAND_BITS);
         read_check({image[p + 1][23:16], image[p][23:16]});
         prog.send(CMD_EXECUTE, OP_RDL_POSTINC, OPERAND_BITS);
         read_check(image[p + 1][15:0]);
         prog.send(CMD_EXECUTE, 24'h040200, OPERAND_BITS);
      end
   endtask : t_readback
   task automatic t_refuse();
      protect = 1'b1;
      prog.send(CMD_EXECUTE, OP_CLR_RDPTR, OPERAND_BITS);
      prog.send(CMD_EXECUTE, OP_MOV_VIS_WRPTR, OPERAND_BITS);
      prog.send(CMD_EXECUTE, OP_RDL, OPERAND_BITS);
      read_check(16'h0000);
      protect = 1'b0;
      prog.send(CMD_EXECUTE, OP_RDL, OPERAND_BITS);
      read_check(image[0][15:0]);
      // stray command code takes no operand, link stays in step
      prog.send(4'h7, 24'h000000, 0);
      read_check(image[0][15:0]);
      prog.send(CMD_EXECUTE, {OP_MOVLIT_HI, 16'h0000, OP_MOVLIT_W0}, OPERAND_BITS);
      prog.send(CMD_EXECUTE, OP_MOV_W0_PAGE, OPERAND_BITS);
      check_word({8'h00, page}, 16'h0000);
      prog.send(CMD_EXECUTE, OP_RDL, OPERAND_BITS);
      read_check(16'h0000);
   endtask : t_refuse
   initial
   begin
      rst_in = 1'b1;
      protect = 1'b0;
      mem_wr = 1'b0;
      mem_addr = 4'h0;
      mem_data = 24'h000000;
      repeat (16) @(posedge clk_in);
      #2;
      rst_in = 1'b0;
      @(posedge clk_in);
      #2;
      check_flag(oe, 1'b0);
      check_word({8'h00, page}, 16'h0000);
      t_ident();
      t_readback();
      t_refuse();
      final_report();
   end
endmodule : tb_exec_memory_readback_and_id
